// File: design/aif_pkg.sv
// aif_pkg: constants and carrier types for the auxiliary interrupt and
// error flag block; shared by the top and its two leaf modules.
package aif_pkg;

  // ==========================================================
  // register map (byte addresses, one word per register)
  localparam logic [3:0] AIF_IDX_IRQ       = 4'h5;
  localparam logic [3:0] AIF_IDX_ERR       = 4'h6;
  // byte address is four times the register index
  localparam logic [7:0] AIF_ADDR_IRQ      = {2'h0, AIF_IDX_IRQ, 2'h0};
  localparam logic [7:0] AIF_ADDR_ERR      = {2'h0, AIF_IDX_ERR, 2'h0};
  localparam logic [7:0] AIF_ADDR_CTRL     = 8'h20;
  localparam logic [7:0] AIF_ADDR_STAT     = 8'h24;

  // ==========================================================
  // field positions
  localparam int AIF_IRQ_SET_BIT  = 7;
  localparam int AIF_IRQ_AUX_BIT  = 4;
  localparam int AIF_IRQ_CRC_BIT  = 2;
  localparam int AIF_ERR_WR_BIT   = 7;
  localparam int AIF_ERR_TEMP_BIT = 6;
  localparam int AIF_ERR_OVF_BIT  = 4;
  localparam int AIF_ERR_COLL_BIT = 3;
  localparam int AIF_ERR_CRC_BIT  = 2;
  localparam int AIF_ERR_PAR_BIT  = 1;
  localparam int AIF_ERR_SOF_BIT  = 0;
  localparam int AIF_CTL_CRCIE_BIT = 2;
  localparam int AIF_CTL_AUXIE_BIT = 4;

  // ==========================================================
  // masks and reset values
  localparam logic [7:0] AIF_IRQ_MASK    = 8'h14;
  localparam logic [7:0] AIF_ERR_MASK    = 8'hDF;
  localparam logic [7:0] AIF_ERR_RUNCLR  = 8'h0F; // cleared at rx start
  localparam logic [7:0] AIF_ERR_CMDCLR  = 8'h9F; // all but overheat
  localparam logic [7:0] AIF_CTL_MASK    = 8'h14;
  localparam logic [7:0] AIF_RESET_BYTE  = 8'h00;

  // ==========================================================
  // receive speed encoding
  typedef enum logic [1:0] {
    AIF_SPD_106 = 2'h0,
    AIF_SPD_212 = 2'h1,
    AIF_SPD_424 = 2'h2,
    AIF_SPD_848 = 2'h3
  } aif_speed_t;

  // ==========================================================
  // carrier of error events from the reader core (same clock)
  typedef struct packed {
    logic       cmd_start;
    logic       auth_active;
    logic       rf_window;
    logic       host_fifo_wr;
    logic       fifo_full_wr;
    logic       overheat;
    logic       rx_startup;
    logic       collision;
    logic       crc_fail;
    logic       parity_fail;
    logic       sof_bad;
    logic       auth_len_bad;
    logic       type_a;
    aif_speed_t speed;
  } aif_err_ev_t;

endpackage : aif_pkg

// File: design/aif_edge_det.sv
// aif_edge_det: synchronises the auxiliary serial input and flags both
// edges; assumes the pin is asynchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module aif_edge_det
  import aif_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // pin and event
  input  wire logic pin_in,
  output logic      edge_pulse
);
  // ==========================================================
  // two-stage synchroniser, then a history flop
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic [2:0] fill_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
      fill_r  <= 3'h0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
      fill_r  <= {fill_r[1:0], 1'b1};
    end
  end

  // rising or falling edge; masked until the history flop holds a real
  // pin sample, so a pin idling high at reset release raises nothing
  assign edge_pulse = (sync2_r ^ prev_r) & fill_r[2];
endmodule : aif_edge_det
`default_nettype wire

// File: design/aif_err_flags.sv
// aif_err_flags: the error flag byte; events come from logic on hclk.
// assumes a start of a command and flag events are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module aif_err_flags
  import aif_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // events
  input  wire aif_err_ev_t ev,
  // state
  output logic [7:0]       flags
);
  // ==========================================================
  // set terms
  logic [7:0] set_w;
  logic [7:0] clr_w;
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic       at106_w;
  logic [7:0] slow_clr_w;

  assign at106_w = (ev.speed == AIF_SPD_106);

  // collision flag is held at zero at the faster rates
  always_comb begin
    slow_clr_w = 8'h00;
    slow_clr_w[AIF_ERR_COLL_BIT] = ~at106_w;
  end

  always_comb begin
    set_w = 8'h00;
    set_w[AIF_ERR_WR_BIT]   = ev.host_fifo_wr &
                              (ev.auth_active | ev.rf_window);
    set_w[AIF_ERR_TEMP_BIT] = ev.overheat;
    set_w[AIF_ERR_OVF_BIT]  = ev.fifo_full_wr;
    set_w[AIF_ERR_COLL_BIT] = ev.collision & at106_w;
    set_w[AIF_ERR_CRC_BIT]  = ev.crc_fail;
    set_w[AIF_ERR_PAR_BIT]  = ev.parity_fail & ev.type_a &
                              at106_w;
    set_w[AIF_ERR_SOF_BIT]  = (ev.sof_bad &
                               (at106_w | ev.auth_active)) |
                              (ev.auth_active & ev.auth_len_bad);
  end

  // clears: receiver start-up, command start and the collision clear at the faster rates; set wins over clear
  assign clr_w = ({8{ev.rx_startup}} & AIF_ERR_RUNCLR) |
                 ({8{ev.cmd_start}} & AIF_ERR_CMDCLR) |
                 slow_clr_w;
  assign flags_nxt = ((flags_r & ~clr_w) | set_w) & AIF_ERR_MASK;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) flags_r <= AIF_RESET_BYTE;
    else          flags_r <= flags_nxt;
  end

  assign flags = flags_r;
endmodule : aif_err_flags
`default_nettype wire

// File: design/aif_top.sv
// aif_top: secondary interrupt request flags and error flags behind an
// AHB-Lite slave; events arrive from the reader core on hclk, the
// auxiliary serial input arrives from a pin.
`timescale 1ns/1ps
`default_nettype none
module aif_top
  import aif_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // reader core events and the auxiliary pin
  input  wire logic        aux_serial_input,
  input  wire logic        crc_compute_command,
  input  wire logic        crc_data_done,
  input  wire logic        rx_crc_check_enable,
  input  wire logic        rx_crc_bad,
  input  wire aif_err_ev_t err_ev,
  // outputs to the rest of the chip
  output logic             irq_request,
  output logic             error_summary_irq,
  output logic             antenna_off
);
  // ==========================================================
  // address phase capture
  logic       wr_pend_r;
  logic [7:0] addr_r;
  logic       take_w;
  logic       wr_irq_w;
  logic       wr_ctl_w;

  assign take_w = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= take_w & hwrite;
      addr_r    <= take_w ? haddr : addr_r;
    end
  end

  assign wr_irq_w = wr_pend_r & (addr_r == AIF_ADDR_IRQ);
  assign wr_ctl_w = wr_pend_r & (addr_r == AIF_ADDR_CTRL);

  // ==========================================================
  // auxiliary input edge and crc completion events
  logic       aux_edge_w;
  logic       crc_done_w;

  aif_edge_det u_edge (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .pin_in     (aux_serial_input),
    .edge_pulse (aux_edge_w)
  );

  assign crc_done_w = crc_compute_command & crc_data_done;

  // ==========================================================
  // secondary interrupt request flags
  logic [7:0] irq_r;
  logic [7:0] irq_nxt;
  logic [7:0] irq_hw_set_w;
  logic [7:0] irq_sw_set_w;
  logic [7:0] irq_sw_clr_w;
  logic [7:0] wmark_w;

  assign wmark_w = hwdata[7:0] & AIF_IRQ_MASK;
  assign irq_sw_set_w = (wr_irq_w & hwdata[AIF_IRQ_SET_BIT]) ?
                        wmark_w : 8'h00;
  assign irq_sw_clr_w = (wr_irq_w & ~hwdata[AIF_IRQ_SET_BIT]) ?
                        wmark_w : 8'h00;

  always_comb begin
    irq_hw_set_w = 8'h00;
    irq_hw_set_w[AIF_IRQ_AUX_BIT] = aux_edge_w;
    irq_hw_set_w[AIF_IRQ_CRC_BIT] = crc_done_w;
  end

  // hardware never clears; a hardware set beats a software clear
  assign irq_nxt = (irq_r & ~irq_sw_clr_w) | irq_sw_set_w |
                   irq_hw_set_w;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_r <= AIF_RESET_BYTE;
    else          irq_r <= irq_nxt & AIF_IRQ_MASK;
  end

  // ==========================================================
  // enable register (own word)
  logic [7:0] ctl_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)      ctl_r <= AIF_RESET_BYTE;
    else if (wr_ctl_w) ctl_r <= hwdata[7:0] & AIF_CTL_MASK;
  end

  // ==========================================================
  // error flags; the rx crc failure feeds the crc check bit
  logic [7:0]  err_w;
  aif_err_ev_t ev_w;

  always_comb begin
    ev_w          = err_ev;
    ev_w.crc_fail = rx_crc_check_enable & rx_crc_bad;
  end

  aif_err_flags u_err (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ev      (ev_w),
    .flags   (err_w)
  );

  // ==========================================================
  // status word: irq pending and summary
  logic       irq_nxt_w;
  logic       sum_nxt_w;
  logic [7:0] stat_w;

  assign sum_nxt_w = |err_w;
  assign irq_nxt_w =
    (irq_r[AIF_IRQ_CRC_BIT] & ctl_r[AIF_CTL_CRCIE_BIT]) |
    (irq_r[AIF_IRQ_AUX_BIT] & ctl_r[AIF_CTL_AUXIE_BIT]);
  assign stat_w = {6'h00, sum_nxt_w, irq_nxt_w};

  // ==========================================================
  // read mux; unmapped reads give zero, always OKAY
  logic [7:0] rd_w;

  assign rd_w = (haddr == AIF_ADDR_IRQ)  ? irq_r :
                (haddr == AIF_ADDR_ERR)  ? err_w :
                (haddr == AIF_ADDR_CTRL) ? ctl_r :
                (haddr == AIF_ADDR_STAT) ? stat_w : 8'h00;

  // ==========================================================
  // registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata            <= 32'h0000_0000;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      irq_request       <= 1'b0;
      error_summary_irq <= 1'b0;
      antenna_off       <= 1'b0;
    end else begin
      hrdata            <= (take_w & ~hwrite) ? {24'h00_0000, rd_w}
                                              : 32'h0000_0000;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      irq_request       <= irq_nxt_w;
      error_summary_irq <= sum_nxt_w;
      antenna_off       <= err_w[AIF_ERR_TEMP_BIT];
    end
  end
endmodule : aif_top
`default_nettype wire

// File: verif/aif_checker.sv
// aif_checker: port-level checks of aif_top, attached by bind
// assumes one hclk domain and the zero-wait slave
`timescale 1ns/1ps
`default_nettype none
module aif_checker
  import aif_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // events and outputs
  input wire aif_err_ev_t err_ev,
  input wire logic        irq_request,
  input wire logic        error_summary_irq,
  input wire logic        antenna_off
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================
  // decode of taken transfers
  wire take_w   = hsel && hready && htrans[1];
  wire rd_irq_w = take_w && !hwrite && haddr == AIF_ADDR_IRQ;
  wire rd_err_w = take_w && !hwrite && haddr == AIF_ADDR_ERR;
  wire wr_w     = take_w && hwrite;
  // ==========================================================
  // assertions
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above byte not zero");
  a_irq_reserved: assert property (
    rd_irq_w |=> (hrdata[7:0] & ~AIF_IRQ_MASK) == 8'h00)
    else $error("irq reserved bits not zero");
  a_err_reserved: assert property (rd_err_w |=> !hrdata[5])
    else $error("error reserved bit not zero");
  a_overheat_off: assert property (
    err_ev.overheat |-> ##[1:3] antenna_off)
    else $error("overheat left antenna on");
  a_overheat_kept: assert property (antenna_off |=> antenna_off)
    else $error("overheat flag cleared");
  a_ovf_summary: assert property (
    err_ev.fifo_full_wr |-> ##[1:3] error_summary_irq)
    else $error("overflow gave no summary request");
  a_temp_summary: assert property (antenna_off |-> error_summary_irq)
    else $error("overheat flag without summary request");
  a_irq_sw_clear: assert property (
    $fell(irq_request) |-> $past(wr_w, 2) || $past(wr_w, 3))
    else $error("irq request dropped without a write");
  c_irq: cover property ($rose(irq_request));
  c_err: cover property ($rose(error_summary_irq));
  c_temp: cover property ($rose(antenna_off));
endmodule : aif_checker
`default_nettype wire

// File: verif/tb_aux_irq_and_error_flags.sv
// tb_aux_irq_and_error_flags: register-level bench of aif_top
// assumes a zero-wait ahb-lite slave and same-clock events
`timescale 1ns/1ps
`default_nettype none
module tb_aux_irq_and_error_flags
  import aif_pkg::*;
;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic        aux = 1'b0, cmd = 1'b0, done = 1'b0, en = 1'b0, bad = 1'b0;
  aif_err_ev_t err_ev = aif_err_ev_t'(15'h0004);
  wire logic [31:0] hrdata;
  wire logic   hreadyout, hresp, irq_request, error_summary_irq, antenna_off;
  logic [31:0] q;
  int          fails = 0, compares = 0, cyc = 0, i;
  // idle event word is type A at 106 kBd
  logic [14:0] ev_tab [11] = '{15'h2804, 15'h1804, 15'h0404, 15'h0084,
    15'h0024, 15'h0014, 15'h200C, 15'h0085, 15'h0026, 15'h0804, 15'h0015};
  logic [31:0] ex_tab [11] = '{32'h80, 32'h80, 32'h10, 32'h08, 32'h02,
    32'h01, 32'h01, 32'h00, 32'h00, 32'h00, 32'h00};
  aif_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .aux_serial_input(aux), .crc_compute_command(cmd),
    .crc_data_done(done), .rx_crc_check_enable(en), .rx_crc_bad(bad),
    .err_ev(err_ev), .irq_request(irq_request),
    .error_summary_irq(error_summary_irq), .antenna_off(antenna_off));
  always #2 hclk = ~hclk;
  // a hang is cut short well past the few hundred cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test;
    end
  end
  // ==========================================================
  // tasks, all entered just after a rising edge
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : xfer
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    xfer(1'b0, a, 8'h00);
    chk(n, e, q);
  endtask : rchk
  task automatic pulse(input logic [14:0] v);
    err_ev <= aif_err_ev_t'(v);
    @(posedge hclk);
    err_ev <= aif_err_ev_t'(15'h0004);
    @(posedge hclk);
  endtask : pulse
  task automatic pin(input string n, input logic e);
    repeat (3) @(posedge hclk);
    chk(n, {31'h0, e}, {31'h0, irq_request});
  endtask : pin
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk("irq reset", AIF_ADDR_IRQ, 32'h0);
    rchk("err reset", AIF_ADDR_ERR, 32'h0);
    xfer(1'b1, AIF_ADDR_IRQ, 8'hFF);
    rchk("irq set", AIF_ADDR_IRQ, 32'h14);
    xfer(1'b1, AIF_ADDR_IRQ, 8'h04);
    rchk("irq clear one", AIF_ADDR_IRQ, 32'h10);
    xfer(1'b1, AIF_ADDR_IRQ, 8'h7F);
    rchk("irq clear all", AIF_ADDR_IRQ, 32'h0);
    for (i = 0; i < 2; i++) begin
      aux <= ~aux;
      repeat (20) @(posedge hclk);
      rchk("aux edge", AIF_ADDR_IRQ, 32'h10);
      xfer(1'b1, AIF_ADDR_IRQ, 8'h10);
    end
    done <= 1'b1;
    @(posedge hclk);
    rchk("crc idle", AIF_ADDR_IRQ, 32'h0);
    cmd <= 1'b1;
    @(posedge hclk);
    done <= 1'b0;
    cmd <= 1'b0;
    rchk("crc done", AIF_ADDR_IRQ, 32'h4);
    aux <= ~aux;
    pin("pin masked", 1'b0);
    xfer(1'b1, AIF_ADDR_CTRL, 8'h04);
    rchk("enable word", AIF_ADDR_CTRL, 32'h04);
    pin("crc to pin", 1'b1);
    rchk("status word", AIF_ADDR_STAT, 32'h01);
    xfer(1'b1, AIF_ADDR_IRQ, 8'h04);
    pin("aux masked", 1'b0);
    xfer(1'b1, AIF_ADDR_CTRL, 8'h10);
    pin("aux to pin", 1'b1);
    xfer(1'b1, AIF_ADDR_IRQ, 8'h10);
    pin("pin cleared", 1'b0);
    for (i = 0; i < 11; i++) begin
      pulse(ev_tab[i]);
      rchk("err", AIF_ADDR_ERR, ex_tab[i]);
      chk("summary", {31'h0, |ex_tab[i]},
          {31'h0, error_summary_irq});
      pulse(15'h0104);
      rchk("rx start", AIF_ADDR_ERR, ex_tab[i] & 32'hF0);
      pulse(15'h4004);
      rchk("cmd start", AIF_ADDR_ERR, 32'h0);
    end
    pulse(15'h0084);
    pulse(15'h0005);
    rchk("coll held zero", AIF_ADDR_ERR, 32'h0);
    bad <= 1'b1;
    @(posedge hclk);
    bad <= 1'b0;
    rchk("crc off", AIF_ADDR_ERR, 32'h0);
    bad <= 1'b1;
    en <= 1'b1;
    @(posedge hclk);
    bad <= 1'b0;
    rchk("crc on", AIF_ADDR_ERR, 32'h4);
    pulse(15'h0104);
    xfer(1'b1, AIF_ADDR_ERR, 8'hFF);
    rchk("err read only", AIF_ADDR_ERR, 32'h0);
    xfer(1'b1, 8'h3C, 8'hFF);
    rchk("unmapped", 8'h3C, 32'h0);
    pulse(15'h0204);
    rchk("overheat", AIF_ADDR_ERR, 32'h40);
    chk("antenna", 32'h1, {31'h0, antenna_off});
    pulse(15'h4004);
    rchk("overheat kept", AIF_ADDR_ERR, 32'h40);
    end_of_test;
  end
endmodule : tb_aux_irq_and_error_flags
bind aif_top aif_checker u_chk (.*);
`default_nettype wire
